//--- isc_regs.sv
// Serial-configured register bank: identification, user serial config
// and the first two clock-control registers, with the sync front logic.
// Assumes serial pins and the sync reference arrive asynchronously and are
// far slower than CLK_I; the timestamp enable comes from the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "isc_cfg.svh"

module isc_regs #(
  parameter logic [15:0] PART_CODE = 16'h5A3C, // Arbitrary value.
  parameter logic [15:0] MAKER_CODE = 16'h00A5 // Arbitrary value.
) (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  input wire logic CS_B_I,
  input wire logic SCLK_I,
  input wire logic SDI_I,
  input wire logic SYNC_REF_I,
  input wire logic TIMESTAMP_ON_I,
  output logic SDO_O,
  output isc_pkg::isc_ctrl_type SYNC_CTRL_O,
  output logic SYNC_ALIGN_O,
  output logic SYNC_EVENT_O,
  output logic LSB_MARK_O
);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic cs_s1, cs_s2, sclk_s1, sclk_s2, sclk_q, sdi_s1, sdi_s2;
  logic sref_s1, sref_s2;

  // Two stages on every pin; the second stage feeds the logic, and SCLK has a third flop for edge detection.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_q <= 1'b0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
      sref_s1 <= 1'b0;
      sref_s2 <= 1'b0;
    end
    else if (CE_I)
    begin
      cs_s1 <= CS_B_I;
      cs_s2 <= cs_s1;
      sclk_s1 <= SCLK_I;
      sclk_s2 <= sclk_s1;
      sclk_q <= sclk_s2;
      sdi_s1 <= SDI_I;
      sdi_s2 <= sdi_s1;
      sref_s1 <= SYNC_REF_I;
      sref_s2 <= sref_s1;
    end
  end

  // ==========================================================
  // Serial framing
  // ==========================================================
  isc_pkg::isc_state_type state;
  logic [3:0] hdr_cnt;
  logic [2:0] bit_cnt;
  logic [15:0] hdr;
  logic [7:0] rx;
  logic [7:0] tx;
  logic [14:0] addr;
  logic is_read;
  logic ascend;
  logic [7:0] usr;
  logic [7:0] cka;
  logic [7:0] ckb;
  logic align_q;

  // Edges come from the synchronised clock, so SCLK must stay well below
  // a quarter of CLK_I; a faster host would lose bits.
  wire sel = ~cs_s2;
  wire sclk_rise = sclk_s2 & ~sclk_q;
  wire sclk_fall = ~sclk_s2 & sclk_q;
  wire [15:0] hdr_next = {hdr[14:0], sdi_s2};
  wire [7:0] rx_next = {rx[6:0], sdi_s2};
  wire head_done = CE_I & sel & sclk_rise & (state == isc_pkg::ISC_HEAD)
                   & (hdr_cnt == `ISC_HDR_LAST);
  wire byte_done = CE_I & sel & sclk_rise & (state == isc_pkg::ISC_DATA)
                   & (bit_cnt == `ISC_BYTE_LAST);
  wire wr_en = byte_done & ~is_read;
  wire hold = usr[`ISC_BIT_HOLD];

  // Freeze, count up or count down after each byte of a stream.
  wire [14:0] addr_up = addr + `ISC_STEP; // RL5
  wire [14:0] addr_dn = addr - `ISC_STEP; // RL5
  wire [14:0] step_addr = hold ? addr : // RL3
                          (ascend ? addr_up : addr_dn); // RL4

  // Read decode, used for the first byte and for every streamed byte.
  function automatic logic [7:0] read_byte(input logic [14:0] a,
                                           input logic asc,
                                           input logic [7:0] u,
                                           input logic [7:0] ca,
                                           input logic [7:0] cb);
    logic [7:0] cfg;
    cfg = 8'h00;
    cfg[`ISC_BIT_ASCEND] = asc;
    cfg[`ISC_BIT_SDO_ACT] = 1'b1;
    unique case (a)
      `ISC_ADDR_CFG_A: read_byte = cfg;
      `ISC_ADDR_PART_LO: read_byte = PART_CODE[7:0]; // RL1
      `ISC_ADDR_PART_HI: read_byte = PART_CODE[15:8]; // RL1
      `ISC_ADDR_MAKER_LO: read_byte = MAKER_CODE[7:0]; // RL2
      `ISC_ADDR_MAKER_HI: read_byte = MAKER_CODE[15:8]; // RL2
      `ISC_ADDR_USR: read_byte = u;
      `ISC_ADDR_CKA: read_byte = ca;
      `ISC_ADDR_CKB: read_byte = cb;
      default: read_byte = 8'h00;
    endcase
  endfunction

  wire [7:0] first_byte = read_byte(hdr_next[14:0], ascend, usr, cka, ckb);
  wire [7:0] next_byte = read_byte(step_addr, ascend, usr, cka, ckb);

  // Header of direction and address, then bytes until chip select rises.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      state <= isc_pkg::ISC_HEAD;
      hdr_cnt <= 4'h0;
      bit_cnt <= 3'h0;
      hdr <= 16'h0000;
      rx <= 8'h00;
      tx <= 8'h00;
      addr <= 15'h0000;
      is_read <= 1'b0;
      SDO_O <= 1'b0;
    end
    else if (CE_I)
    begin
      if (!sel)
      begin
        state <= isc_pkg::ISC_HEAD;
        hdr_cnt <= 4'h0;
        bit_cnt <= 3'h0;
        SDO_O <= 1'b0;
      end
      else if (head_done)
      begin
        state <= isc_pkg::ISC_DATA;
        is_read <= hdr_next[15];
        addr <= hdr_next[14:0];
        tx <= first_byte;
        bit_cnt <= 3'h0;
      end
      else if (byte_done)
      begin
        addr <= step_addr; // RL3 RL4
        tx <= next_byte;
        bit_cnt <= 3'h0;
      end
      else if (sclk_rise)
      begin
        unique case (state)
          isc_pkg::ISC_HEAD:
          begin
            hdr <= hdr_next;
            hdr_cnt <= hdr_cnt + 4'h1;
          end
          isc_pkg::ISC_DATA:
          begin
            rx <= rx_next;
            bit_cnt <= bit_cnt + 3'h1;
          end
        endcase
      end
      else if (sclk_fall && state == isc_pkg::ISC_DATA && is_read)
      begin
        SDO_O <= tx[7];
        tx <= {tx[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // Register file
  // ==========================================================
  // Identification offsets have no storage, so a write there is dropped.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      ascend <= `ISC_RST_ASCEND;
      usr <= `ISC_RST_USR;
      cka <= `ISC_RST_CKA; // RL6 RL7
      ckb <= `ISC_RST_CKB;
    end
    else if (wr_en)
    begin
      unique case (addr)
        `ISC_ADDR_CFG_A: ascend <= rx_next[`ISC_BIT_ASCEND];
        `ISC_ADDR_USR: usr <= rx_next;
        `ISC_ADDR_CKA: cka <= rx_next; // RL6 RL7 RL9 RL11
        `ISC_ADDR_CKB: ckb <= rx_next;
        default: ; // RL16
      endcase
    end
  end

  // Control fields go out straight from the register flops.
  assign SYNC_CTRL_O.recv_on = cka[`ISC_BIT_RECV]; // RL6
  assign SYNC_CTRL_O.proc_on = cka[`ISC_BIT_PROC]; // RL7
  assign SYNC_CTRL_O.fine_scale = cka[`ISC_BIT_FINE]; // RL9
  assign SYNC_CTRL_O.delay_sel = cka[`ISC_SEL_HI:`ISC_SEL_LO]; // RL11
  assign SYNC_CTRL_O.pol_invert = ckb[`ISC_BIT_INV]; // RL14
  assign SYNC_CTRL_O.timestamp_on = ckb[`ISC_BIT_TS]; // RL15
  assign SYNC_CTRL_O.sample_clock_dc = ckb[`ISC_BIT_SCDC];
  assign SYNC_CTRL_O.sync_input_dc = ckb[`ISC_BIT_SIDC];

  // ==========================================================
  // Sync reference front
  // ==========================================================
  // The event pulse needs both enables, so a processor turned on before
  // the receiver sees an event when the receiver comes on with the aligned sync high.
  wire align_now = cka[`ISC_BIT_RECV]
                   & (sref_s2 ^ ckb[`ISC_BIT_INV]); // RL6 RL14
  wire event_now = align_now & ~align_q & cka[`ISC_BIT_PROC]; // RL7 RL8
  wire mark_now = sref_s2 & ckb[`ISC_BIT_TS] & TIMESTAMP_ON_I; // RL15

  // Registered so that every output leaves from a flop.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      align_q <= 1'b0;
      SYNC_ALIGN_O <= 1'b0;
      SYNC_EVENT_O <= 1'b0;
      LSB_MARK_O <= 1'b0;
    end
    else if (CE_I)
    begin
      align_q <= align_now;
      SYNC_ALIGN_O <= align_now;
      SYNC_EVENT_O <= event_now;
      LSB_MARK_O <= mark_now;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb_main @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  a_part_code_read: assert property (head_done && hdr_next[15] // RL1
    && hdr_next[14:0] == `ISC_ADDR_PART_LO |=> tx == PART_CODE[7:0])
    else $error("part code byte wrong");
  a_maker_code_read: assert property (head_done && hdr_next[15] // RL2
    && hdr_next[14:0] == `ISC_ADDR_MAKER_HI |=> tx == MAKER_CODE[15:8])
    else $error("maker code byte wrong");
  a_addr_frozen: assert property (byte_done && hold // RL3
    |=> addr == $past(addr))
    else $error("frozen address moved");
  a_addr_step_up: assert property (byte_done && !hold && ascend // RL4
    |=> addr == $past(addr) + `ISC_STEP)
    else $error("address did not count up");
  a_addr_step_down: assert property (byte_done && !hold && !ascend // RL5
    |=> addr == $past(addr) - `ISC_STEP)
    else $error("address did not count down");
  a_recv_enable: assert property (wr_en && addr == `ISC_ADDR_CKA // RL6
    |=> SYNC_CTRL_O.recv_on == $past(rx_next[`ISC_BIT_RECV]))
    else $error("receiver enable not written");
  a_event_needs_enables: assert property (SYNC_EVENT_O // RL7
    |-> $past(cka[`ISC_BIT_PROC]) && $past(cka[`ISC_BIT_RECV]))
    else $error("sync event while disabled");
  a_fine_scale_write: assert property (wr_en && addr == `ISC_ADDR_CKA // RL9
    |=> SYNC_CTRL_O.fine_scale == $past(rx_next[`ISC_BIT_FINE]))
    else $error("fine scale not written");
  a_delay_select: assert property (wr_en && addr == `ISC_ADDR_CKA // RL11
    |=> SYNC_CTRL_O.delay_sel == $past(rx_next[3:0]))
    else $error("delay select not written");
  a_sync_invert: assert property (CE_I // RL14
    |=> SYNC_ALIGN_O == ($past(cka[`ISC_BIT_RECV])
        && ($past(sref_s2) != $past(ckb[`ISC_BIT_INV]))))
    else $error("aligned sync level wrong");
  a_lsb_marker: assert property (CE_I // RL15
    |=> LSB_MARK_O == ($past(sref_s2) && $past(ckb[`ISC_BIT_TS])
        && $past(TIMESTAMP_ON_I)))
    else $error("LSB marker wrong");
  a_id_write_dropped: assert property (wr_en // RL16
    && (addr == `ISC_ADDR_PART_LO || addr == `ISC_ADDR_MAKER_LO)
    |=> $stable(cka) && $stable(ckb) && $stable(usr) && $stable(ascend))
    else $error("identification write changed state");

endmodule

`default_nettype wire

//--- isc_cfg.svh
// Register offsets, field positions, reset values and counts for the
// identification and sync clock-control register bank.
// Assumes a serial port with one direction bit, a 15-bit address and bytes.
//
// Operation
// RL1 - The part-family code register always reads back one fixed 16-bit code.
// RL2 - The maker code register at offset 0xC always reads one fixed code.
// RL3 - With the address-freeze bit set, streaming keeps the same address.
// RL4 - With the address-freeze bit clear (reset), streaming steps the address.
// RL5 - The direction bit set (default) counts up per byte, clear counts down.
// RL6 - Bit 5 of clock control A turns the sync receiver on, off after reset.
// RL7 - Bit 6 of clock control A lets sync events be acted on, off at reset.
// RL8 - Software turns the receiver on before it turns the processor on.
// RL9 - Bit 4 of clock control A selects the finer sync window delay steps.
// RL10 - Software picks fine steps at high clock rates with several windows.
// RL11 - Bits 3 to 0 of clock control A choose the sync capture delay.
// RL12 - Software picks the delay from the reported sync edge position.
// RL13 - Software leaves the delay at zero when auto calibration is used.
// RL14 - Bit 0 of clock control B inverts the sync reference for alignment.
// RL15 - Sync timestamp bit 3 and the timestamp enable put sync on the LSB.
// RL16 - Writes to either identification register change nothing.
`ifndef ISC_CFG_SVH
`define ISC_CFG_SVH

`define ISC_ADDR_CFG_A 15'h0000
`define ISC_ADDR_PART_LO 15'h0004
`define ISC_ADDR_PART_HI 15'h0005
`define ISC_ADDR_MAKER_LO 15'h000C
`define ISC_ADDR_MAKER_HI 15'h000D
`define ISC_ADDR_USR 15'h0010
`define ISC_ADDR_CKA 15'h0029
`define ISC_ADDR_CKB 15'h002A

`define ISC_BIT_ASCEND 5
`define ISC_BIT_SDO_ACT 4
`define ISC_BIT_HOLD 0
`define ISC_BIT_PROC 6
`define ISC_BIT_RECV 5
`define ISC_BIT_FINE 4
`define ISC_SEL_HI 3
`define ISC_SEL_LO 0
`define ISC_BIT_TS 3
`define ISC_BIT_SCDC 2
`define ISC_BIT_SIDC 1
`define ISC_BIT_INV 0

`define ISC_RST_ASCEND 1'b1
`define ISC_RST_USR 8'h00
`define ISC_RST_CKA 8'h00
`define ISC_RST_CKB 8'h00

`define ISC_HDR_LAST 4'hF
`define ISC_BYTE_LAST 3'h7
`define ISC_STEP 15'h0001

`endif

//--- isc_pkg.sv
// Types shared by the identification and sync clock-control bank.
// Assumes the constants header is included by the design file.
package isc_pkg;

  typedef enum logic [0:0] {
    ISC_HEAD,
    ISC_DATA
  } isc_state_type;

  typedef struct packed {
    logic recv_on;
    logic proc_on;
    logic fine_scale;
    logic [3:0] delay_sel;
    logic pol_invert;
    logic timestamp_on;
    logic sample_clock_dc;
    logic sync_input_dc;
  } isc_ctrl_type;

endpackage

//--- isc_host.sv
// Host model driving the serial configuration port of the register bank.
// Assumes a 100 MHz clock; each serial clock half lasts five clocks.
`timescale 1ns/1ns
`default_nettype none

module isc_host (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic cs_b_o,
  output logic sclk_o,
  output logic sdi_o,
  output logic rd_valid_o,
  output logic [7:0] rd_byte_o
);
  // ==========================================
  // Idle state
  // The serial clock stands still between frames.
  initial
  begin
    cs_b_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    rd_valid_o = 1'b0;
    rd_byte_o = 8'h00;
  end

  // ==========================================
  // Transfers
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Five clocks a half keeps well above the three the synchronisers need.
  task automatic bit_io(input logic v, output logic s);
    sclk_o = 1'b0;
    sdi_o = v;
    wait_clk(5);
    s = sdo_i;
    sclk_o = 1'b1;
    wait_clk(5);
  endtask

  // One frame: header, then n bytes, byte 0 in the low bits of wd.
  task automatic xfer(input logic rd, input logic [14:0] a, input int n,
                      input logic [31:0] wd);
    logic [15:0] h;
    logic [7:0] r;
    logic s;
    h = {rd, a};
    cs_b_o = 1'b0;
    wait_clk(3);
    for (int i = 15; i >= 0; i--)
      bit_io(h[i], s);
    for (int b = 0; b < n; b++)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        bit_io(wd[8*b+i], s);
        r[i] = s;
      end
      if (rd)
      begin
        rd_byte_o = r;
        rd_valid_o = 1'b1;
        wait_clk(1);
        rd_valid_o = 1'b0;
      end
    end
    sclk_o = 1'b0;
    wait_clk(2);
    cs_b_o = 1'b1;
    // Released data line flips so stale data never looks valid.
    sdi_o = ~sdi_o;
    wait_clk(4);
  endtask
endmodule
`default_nettype wire

//--- isc_regs_tb_top.sv
// Self-checking testbench of the identification and sync clock bank.
// Assumes isc_host drives the serial port; reads are checked from a queue.
`timescale 1ns/1ns
`default_nettype none

module isc_regs_tb_top;
  logic CLK_I, RST_B_I, CE_I, CS_B_I, SCLK_I, SDI_I;
  logic SYNC_REF_I, TIMESTAMP_ON_I, SDO_O, SYNC_ALIGN_O, SYNC_EVENT_O;
  logic LSB_MARK_O, rd_valid, hit;
  logic [7:0] rd_byte, v, w;
  isc_pkg::isc_ctrl_type SYNC_CTRL_O;
  int miscompares = 0;
  int checks = 0;
  int seed = 97549;
  logic [7:0] exp_q[$];
  localparam logic [15:0] PART = 16'h1234; // Arbitrary value.
  localparam logic [15:0] MAKER = 16'h0C3A; // Arbitrary value.

  isc_regs #(.PART_CODE(PART), .MAKER_CODE(MAKER)) dut (.CLK_I(CLK_I),
    .RST_B_I(RST_B_I), .CE_I(CE_I), .CS_B_I(CS_B_I), .SCLK_I(SCLK_I),
    .SDI_I(SDI_I), .SYNC_REF_I(SYNC_REF_I), .TIMESTAMP_ON_I(TIMESTAMP_ON_I),
    .SDO_O(SDO_O), .SYNC_CTRL_O(SYNC_CTRL_O), .SYNC_ALIGN_O(SYNC_ALIGN_O),
    .SYNC_EVENT_O(SYNC_EVENT_O), .LSB_MARK_O(LSB_MARK_O));
  isc_host host (.clk_i(CLK_I), .sdo_i(SDO_O), .cs_b_o(CS_B_I),
    .sclk_o(SCLK_I), .sdi_o(SDI_I), .rd_valid_o(rd_valid),
    .rd_byte_o(rd_byte));

  // ==========================================
  // Clock and helpers
  initial CLK_I = 1'b0;
  always #5 CLK_I = ~CLK_I;

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic rd(input logic [14:0] a, input int n, input logic [31:0] e);
    for (int b = 0; b < n; b++)
      exp_q.push_back(e[8*b+:8]);
    host.xfer(1'b1, a, n, 32'h0000_0000);
  endtask

  task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
    host.xfer(1'b0, a, n, d);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask

  // A read whose bytes never came back must not pass unnoticed.
  task automatic close_out;
    chk("pending reads", 16'h0000, 16'(exp_q.size()));
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================
  // Read watcher: every returned byte is matched to the oldest note.
  always @(posedge CLK_I)
    if (rd_valid === 1'b1)
      chk("read byte", exp_q.size() ? exp_q.pop_front() : 16'hxxxx, rd_byte);

  // Watchdog so that a stuck run still reaches the verdict.
  initial
  begin
    repeat (90000) @(posedge CLK_I);
    miscompares++;
    $display("unexpected timeout exp done got hang");
    close_out();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    RST_B_I = 1'b0;
    CE_I = 1'b1;
    SYNC_REF_I = 1'b0;
    TIMESTAMP_ON_I = 1'b0;
    tick(5);
    RST_B_I = 1'b1;
    tick(3);
    rd(15'h0010, 1, 32'h0000_0000);
    rd(15'h0029, 2, 32'h0000_0000);
    chk("ctrl", 16'h0000, {5'h00, SYNC_CTRL_O});
    $display("test reset values done");
    v = 8'($random(seed));
    wr(15'h0004, 2, {16'h0000, v, ~v});
    wr(15'h000C, 1, {24'h00_0000, v});
    rd(15'h0004, 2, {16'h0000, PART});
    rd(15'h000C, 2, {16'h0000, MAKER});
    rd(15'h0020, 1, 32'h0000_0000);
    $display("test identification done");
    for (int i = 0; i < 3; i++)
    begin
      v = 8'($random(seed));
      wr(15'h0029, 1, 32'h0000_0020);
      w = {3'h3, v[4], (i == 2) ? 4'h0 : v[3:0]};
      wr(15'h0029, 1, {24'h00_0000, w});
      chk("ctrl a", {7'h03, w[4:0], 4'h0}, {5'h00, SYNC_CTRL_O});
      rd(15'h0029, 1, {24'h00_0000, w});
    end
    for (int i = 0; i < 4; i++)
    begin
      w = 8'h01 << i;
      wr(15'h002A, 1, {24'h00_0000, w});
      chk("ctrl b", {w[0], w[3], w[2], w[1]}, SYNC_CTRL_O[3:0]);
    end
    $display("test clock control done");
    wr(15'h0000, 1, 32'h0000_0000);
    wr(15'h002A, 2, 32'h0000_6908);
    rd(15'h002A, 2, 32'h0000_6908);
    wr(15'h0000, 1, 32'h0000_0020);
    wr(15'h0010, 1, 32'h0000_0001);
    wr(15'h0029, 2, 32'h0000_2C11);
    rd(15'h0029, 2, 32'h0000_2C2C);
    wr(15'h0010, 1, 32'h0000_0000);
    rd(15'h002A, 1, 32'h0000_0008);
    $display("test streaming done");
    wr(15'h0029, 1, 32'h0000_0060);
    wr(15'h002A, 1, 32'h0000_0008);
    TIMESTAMP_ON_I = 1'b1;
    SYNC_REF_I = 1'b1;
    hit = 1'b0;
    for (int k = 0; k < 8 && !hit; k++)
    begin
      tick(1);
      hit = (SYNC_EVENT_O === 1'b1);
    end
    chk("event", 16'h0001, {15'h0000, hit});
    tick(1);
    chk("event end", 16'h0000, {15'h0000, SYNC_EVENT_O});
    tick(3);
    chk("align mark", 16'h0003, {14'h0000, SYNC_ALIGN_O, LSB_MARK_O});
    // The marker needs the general timestamp enable as well.
    TIMESTAMP_ON_I = 1'b0;
    tick(2);
    chk("mark gated", 16'h0002, {14'h0000, SYNC_ALIGN_O, LSB_MARK_O});
    wr(15'h002A, 1, 32'h0000_0001);
    tick(5);
    chk("inverted", 16'h0000, {14'h0000, SYNC_ALIGN_O, LSB_MARK_O});
    SYNC_REF_I = 1'b0;
    tick(5);
    chk("inv low", 16'h0002, {14'h0000, SYNC_ALIGN_O, LSB_MARK_O});
    // With the enable low a pin change must not reach the outputs.
    CE_I = 1'b0;
    SYNC_REF_I = 1'b1;
    tick(5);
    chk("frozen", 16'h0002, {14'h0000, SYNC_ALIGN_O, LSB_MARK_O});
    CE_I = 1'b1;
    tick(5);
    chk("thawed", 16'h0000, {14'h0000, SYNC_ALIGN_O, LSB_MARK_O});
    $display("test sync front done");
    // A second reset in mid-run must restore the direction bit and both clock-control defaults.
    wr(15'h0000, 1, 32'h0000_0000);
    RST_B_I = 1'b0;
    tick(5);
    RST_B_I = 1'b1;
    tick(3);
    chk("reset ctrl", 16'h0000, {5'h00, SYNC_CTRL_O});
    chk("reset sync", 16'h0000, {14'h0000, SYNC_ALIGN_O, LSB_MARK_O});
    rd(15'h0000, 1, 32'h0000_0030);
    $display("test mid reset done");
    close_out();
  end
endmodule
`default_nettype wire
